//--- pkg/boim_pkg.sv
// package for the jump / or / increment / move execution block
package boim_pkg;
  // 14-bit instruction word fields
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int JUMP_LIT_W = 11;
  localparam int LATCH_HI_BIT = 4;
  localparam int LATCH_LO_BIT = 3;
  localparam int STATUS_Z_BIT = 2;
  // opcode patterns (upper bits of the word)
  localparam logic [2:0] OPC_JUMP = 3'h5; // bits 13:11 = 101
  localparam logic [5:0] OPC_ORLIT = 6'h38; // bits 13:8 = 111000
  localparam logic [5:0] OPC_INCREMENT_FILE_REG = 6'h0a; // bits 13:8 = 001010
  localparam logic [5:0] OPC_ORWF = 6'h04; // bits 13:8 = 000100
  localparam logic [5:0] OPC_MOVE_FILE_REG = 6'h08; // bits 13:8 = 001000
  // reset values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  // a jump costs this many instruction cycles
  localparam int JUMP_CYCLES = 2;

  typedef enum logic [1:0] {
    BOIM_OP_NONE = 2'b00,
    BOIM_OP_ALU = 2'b01,
    BOIM_OP_JUMP = 2'b11
  } boim_op_t;

  // file register write request
  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } boim_fwrite_t;

  typedef enum logic [1:0] {
    BOIM_ST_EXEC = 2'b00,
    BOIM_ST_FLUSH = 2'b01
  } boim_state_t;
endpackage : boim_pkg

//--- verilog/boim_alu.sv
// combinational result unit for or / increment / move
`timescale 1ns/10ps
`default_nettype none
module boim_alu (
  input wire logic [13:0] insn,
  input wire logic [7:0] acc,
  input wire logic [7:0] fdata,
  output logic [7:0] result,
  output logic hit,
  output logic to_file,
  output logic is_orlit
);
  wire logic [5:0] opc = insn[13:8];
  wire logic is_inc = (opc == boim_pkg::OPC_INCREMENT_FILE_REG);
  wire logic is_orwf = (opc == boim_pkg::OPC_ORWF);
  wire logic is_mov = (opc == boim_pkg::OPC_MOVE_FILE_REG);
  // result selection
  assign is_orlit = (opc == boim_pkg::OPC_ORLIT);
  assign hit = is_orlit | is_inc | is_orwf | is_mov;
  assign to_file = ~is_orlit & insn[boim_pkg::DEST_BIT];
  assign result = is_orlit ? (acc | insn[7:0]) :
                  is_inc ? 8'(fdata + 8'h01) :
                  is_orwf ? (acc | fdata) :
                  fdata;
endmodule : boim_alu
`default_nettype wire

//--- verilog/boim_exec.sv
// execution stage for jump, or-literal, increment, or-file and move-file
`timescale 1ns/10ps
`default_nettype none
module boim_exec (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0] fdata,
  input wire logic [7:0] branch_high_latch,
  output logic [12:0] program_counter,
  output logic [7:0] accumulator,
  output logic [7:0] status,
  output boim_pkg::boim_fwrite_t fwrite,
  output logic flush,
  output logic busy
);
  boim_pkg::boim_state_t state;
  boim_pkg::boim_state_t next_state;
  logic [7:0] result;
  logic alu_hit;
  logic to_file;
  logic is_orlit;

  boim_alu u_alu (
    .insn(insn),
    .acc(accumulator),
    .fdata(fdata),
    .result(result),
    .hit(alu_hit),
    .to_file(to_file),
    .is_orlit(is_orlit)
  );

  // decode; during the flush cycle the prefetched word is discarded
  // fdata is the far side's combinational read of insn[6:0] in this very cycle, so an
  // operand arrives together with its word and every ordinary word finishes in one cycle.
  // a jump cannot do that: the word fetched behind it is already in flight when the new
  // counter lands, hence one dead cycle in which nothing is taken and the counter holds.
  // clk_en gates every flop below, so a frozen core keeps its flush state as well; the
  // dead cycle is only spent on an enabled edge, never lost while the core is stalled.
  wire logic in_exec = (state == boim_pkg::BOIM_ST_EXEC);
  wire logic take = clk_en & insn_valid & in_exec;
  wire logic is_jump = (insn[13:11] == boim_pkg::OPC_JUMP);
  wire logic do_jump = take & is_jump;
  wire logic do_alu = take & alu_hit & ~is_jump;
  wire logic do_step = take & ~is_jump;
  wire logic zero = (result == 8'h00);
  // per-opcode names used by the checks below
  wire logic op_inc = (insn[13:8] == boim_pkg::OPC_INCREMENT_FILE_REG);
  wire logic op_orwf = (insn[13:8] == boim_pkg::OPC_ORWF);
  wire logic op_move_file_reg = (insn[13:8] == boim_pkg::OPC_MOVE_FILE_REG);
  wire logic dest_file = insn[boim_pkg::DEST_BIT];
  wire logic [12:0] jump_target = {branch_high_latch[boim_pkg::LATCH_HI_BIT:boim_pkg::LATCH_LO_BIT],
                                   insn[10:0]};
  wire logic [12:0] next_pc = do_jump ? jump_target :
                              do_step ? 13'(program_counter + 13'h0001) : program_counter;
  assign next_state = do_jump ? boim_pkg::BOIM_ST_FLUSH :
                      (clk_en ? boim_pkg::BOIM_ST_EXEC : state);

  // counter and sequencing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      program_counter <= boim_pkg::PC_RESET;
      state <= boim_pkg::BOIM_ST_EXEC;
      flush <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      program_counter <= next_pc;
      state <= next_state;
      flush <= do_jump;
      busy <= do_jump;
    end
  end

  // accumulator and zero flag; only the zero bit of status ever moves
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      accumulator <= boim_pkg::ACC_RESET;
      status <= boim_pkg::STATUS_RESET;
    end else if (do_alu) begin
      if (!to_file) begin
        accumulator <= result;
      end
      status[boim_pkg::STATUS_Z_BIT] <= zero;
    end
  end

  // file write port, pulse for one enabled cycle, held through a stall
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fwrite <= '0;
    end else if (clk_en) begin
      fwrite.en <= do_alu & to_file;
      fwrite.addr <= insn[6:0];
      fwrite.data <= result;
    end
  end

  a_jump_target: assert property (@(posedge ref_clk) disable iff (reset)
    do_jump |=> program_counter == {$past(branch_high_latch[4:3]), $past(insn[10:0])})
    else $error("jump target wrong");
  a_jump_two_cycle: assert property (@(posedge ref_clk) disable iff (reset)
    do_jump |=> (busy && !in_exec))
    else $error("jump did not take a second cycle");
  a_zero_flag: assert property (@(posedge ref_clk) disable iff (reset)
    do_alu |=> status[2] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  a_status_other: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> {status[7:3], status[1:0]} == $past({status[7:3], status[1:0]}))
    else $error("other status bits changed");
  a_orlit_acc: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && is_orlit) |=> accumulator == ($past(accumulator) | $past(insn[7:0])))
    else $error("or literal result wrong");
  a_file_dest: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && to_file) |=> fwrite.en && accumulator == $past(accumulator))
    else $error("file destination mishandled");
  a_inc_acc: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && insn[13:8] == 6'h0a && !insn[7])
      |=> accumulator == 8'($past(fdata) + 8'h01))
    else $error("increment result wrong");
  a_move_one: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && insn[13:8] == 6'h08 && !insn[7]) |=> (accumulator == $past(fdata) && !busy))
    else $error("move not single cycle");
  a_orwf_file: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && insn[13:8] == 6'h04 && insn[7])
      |=> fwrite.data == ($past(accumulator) | $past(fdata)))
    else $error("or file result wrong");

  // the checks below rebuild each answer from the operands, not from result, so a
  // broken result unit shows up here rather than agreeing with itself

  // low counter bits come straight from the immediate
  a_jump_low: assert property (@(posedge ref_clk) disable iff (reset)
    do_jump
      |=> program_counter[10:0] == $past(insn[10:0]))
    else $error("jump low bits wrong");

  // high counter bits come from the latch, never from the old counter
  a_jump_high: assert property (@(posedge ref_clk) disable iff (reset)
    do_jump
      |=> program_counter[12:11] == $past(branch_high_latch[4:3]))
    else $error("jump high bits wrong");

  // the dead cycle after a jump takes nothing and moves nothing
  a_flush_drop: assert property (@(posedge ref_clk) disable iff (reset)
    (!in_exec && clk_en)
      |=> (program_counter == $past(program_counter) && !fwrite.en))
    else $error("word executed in flush cycle");

  // the dead cycle lasts one enabled cycle only
  a_flush_once: assert property (@(posedge ref_clk) disable iff (reset)
    (flush && clk_en)
      |=> (!flush && !busy && in_exec))
    else $error("flush longer than one cycle");

  // a jump leaves accumulator, status and the file alone
  a_jump_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    do_jump
      |=> (status == $past(status) && accumulator == $past(accumulator) && !fwrite.en))
    else $error("jump touched data state");

  // or-literal zero flag rebuilt from the operands
  a_orlit_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && is_orlit)
      |=> status[2] == (($past(accumulator) | $past(insn[7:0])) == 8'h00))
    else $error("or literal zero flag wrong");

  // increment back into the file register
  a_inc_file: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && op_inc && dest_file)
      |=> (fwrite.en && fwrite.data == 8'($past(fdata) + 8'h01)))
    else $error("increment write back wrong");

  // an increment gives zero only when the operand was all ones
  a_inc_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && op_inc)
      |=> status[2] == ($past(fdata) == 8'hff))
    else $error("increment zero flag wrong");

  // or-file into the accumulator
  a_orwf_acc: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && op_orwf && !dest_file)
      |=> accumulator == ($past(accumulator) | $past(fdata)))
    else $error("or file accumulator wrong");

  // move-file back into itself keeps address and value
  a_move_file: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && op_move_file_reg && dest_file)
      |=> (fwrite.data == $past(fdata) && fwrite.addr == $past(insn[6:0])))
    else $error("move write back wrong");

  // move-file tests the register whichever the destination
  a_move_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && op_move_file_reg)
      |=> status[2] == ($past(fdata) == 8'h00))
    else $error("move zero flag wrong");

  // every word but a jump advances the counter by one in one cycle
  a_step_pc: assert property (@(posedge ref_clk) disable iff (reset)
    do_step
      |=> (program_counter == 13'($past(program_counter) + 13'h0001) && !busy))
    else $error("counter step wrong");

  // a stalled core keeps status and the rest of its state
  a_freeze_all: assert property (@(posedge ref_clk) disable iff (reset)
    !clk_en
      |=> (status == $past(status) && program_counter == $past(program_counter)
           && accumulator == $past(accumulator) && fwrite == $past(fwrite)))
    else $error("state moved while stalled");

  // an accumulator destination never writes the file
  a_acc_dest: assert property (@(posedge ref_clk) disable iff (reset)
    (do_alu && !to_file)
      |=> !fwrite.en)
    else $error("file written for accumulator destination");
endmodule : boim_exec
`default_nettype wire

//--- test/boim_rf.sv
// register file model on the far side of the execution block
`timescale 1ns/10ps
`default_nettype none
module boim_rf (
  input wire logic ref_clk,
  input wire logic [6:0] raddr,
  input wire boim_pkg::boim_fwrite_t fwrite,
  output logic [7:0] fdata
);
  logic [7:0] mem [128];
  // all-ones and zero cells so increments wrap
  initial for (int i = 0; i < 128; i++) mem[i] = i[0] ? 8'hff : 8'h00;
  // a pending write is seen at once, so a word right behind a write-back reads fresh data
  assign fdata = (fwrite.en && fwrite.addr == raddr) ? fwrite.data : mem[raddr];
  // write lands one edge after the request shows
  always @(posedge ref_clk) if (fwrite.en) mem[fwrite.addr] <= fwrite.data;
endmodule : boim_rf
`default_nettype wire

//--- test/branch_or_inc_move_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
module branch_or_inc_move_exec_tb;
  logic ref_clk = 0, reset = 1, clk_en = 1, insn_valid = 0, flush, busy, fl, zf, f;
  logic [13:0] insn = 14'h0000, w;
  logic [7:0] bhl = 8'h00, fdata, accumulator, status, acc, r;
  logic [12:0] program_counter, pc;
  boim_pkg::boim_fwrite_t fwrite, fw;
  int failures = 0, checks = 0, seed = 32'h095f, sel;
  logic [5:0] ops [5] = '{6'h38, 6'h0a, 6'h04, 6'h08, 6'h3a};
  always #5 ref_clk = ~ref_clk;
  boim_exec dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .insn_valid(insn_valid),
    .insn(insn), .fdata(fdata), .branch_high_latch(bhl), .program_counter(program_counter),
    .accumulator(accumulator), .status(status), .fwrite(fwrite), .flush(flush), .busy(busy));
  boim_rf rf (.ref_clk(ref_clk), .raddr(insn[6:0]), .fwrite(fwrite), .fdata(fdata));
  task chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // expected effect of one enabled cycle; fd is what the file read gave
  function void step(logic v, logic [13:0] i, logic [7:0] fd);
    fw.en = 1'b0;
    f = i[13:8] inside {boim_pkg::OPC_INCREMENT_FILE_REG, boim_pkg::OPC_MOVE_FILE_REG, boim_pkg::OPC_ORWF};
    if (fl) fl = 1'b0; // word after a jump is dropped
    else if (v && i[13:11] == boim_pkg::OPC_JUMP) begin
      pc = {bhl[4:3], i[10:0]};
      fl = 1'b1;
    end else if (v) begin
      pc = pc + 13'h1;
      r = i[13:8] == boim_pkg::OPC_INCREMENT_FILE_REG ? fd + 8'h1 : i[13:8] == boim_pkg::OPC_MOVE_FILE_REG ? fd :
          acc | (i[13:8] == boim_pkg::OPC_ORWF ? fd : i[7:0]);
      if (f && i[7]) fw = {1'b1, i[6:0], r};
      else if (f || i[13:8] == boim_pkg::OPC_ORLIT) acc = r;
      if (f || i[13:8] == boim_pkg::OPC_ORLIT) zf = r == 8'h00;
    end
  endfunction : step
  // random words with a forced run of every opcode first, its or-literal words each landing in the dead cycle behind a jump
  initial begin
    pc = 13'h0;
    acc = 8'h00;
    zf = 0;
    fl = 0;
    fw = '0;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge ref_clk);
      w = 14'($random(seed));
      sel = k < 12 ? k % 6 : $unsigned($random(seed)) % 6;
      if (sel == 0) w[13:11] = boim_pkg::OPC_JUMP;
      else w[13:8] = ops[sel - 1];
      if (k == 0) w[10:0] = 11'h7ff;
      insn <= w;
      insn_valid <= k < 12 || $random(seed) % 4 != 0;
      clk_en <= k < 12 || $random(seed) % 8 != 0;
      bhl <= k == 0 ? 8'h18 : 8'($random(seed));
      #1;
      chk("pc", 16'(program_counter), 16'(pc));
      chk("acc", 16'(accumulator), 16'(acc));
      chk("status", 16'(status), {13'h0000, zf, 2'h0});
      chk("flush", 16'(flush), 16'(fl));
      chk("busy", 16'(busy), 16'(fl));
      chk("fw_en", 16'(fwrite.en), 16'(fw.en));
      if (fw.en) chk("fwrite", 16'(fwrite), 16'(fw));
      if (clk_en) step(insn_valid, insn, fdata);
    end
    finish_test();
  end
  // cut a hang short
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule : branch_or_inc_move_exec_tb
`default_nettype wire
